// ===== src/phy_status_regs.svh
// register offsets, field positions, reset values and frame constants of the phy status bank
`ifndef PHY_STATUS_REGS_SVH
`define PHY_STATUS_REGS_SVH

// management register addresses
`define PHY_LINK_STATUS_ADDR 5'h01
`define PHY_IDENTIFIER_HIGH_ADDR 5'h02

// status word reset value
`define PHY_LINK_STATUS_RESET 16'h7849

// status field positions
`define ST_T4_BIT 15
`define ST_X_FD_BIT 14
`define ST_X_HD_BIT 13
`define ST_10_FD_BIT 12
`define ST_10_HD_BIT 11
`define ST_RSVD_HI 10
`define ST_RSVD_LO 7
`define ST_PRE_SUPP_BIT 6
`define ST_AN_DONE_BIT 5
`define ST_REM_FAULT_BIT 4
`define ST_AN_ABLE_BIT 3
`define ST_LINK_BIT 2
`define ST_JABBER_BIT 1
`define ST_EXT_CAP_BIT 0

// fixed capability values and the reset value of the strap-set ability bit
`define CAP_T4 1'h0
`define CAP_X_FD 1'h1
`define CAP_X_HD 1'h1
`define CAP_10_FD 1'h1
`define CAP_10_HD 1'h1
`define CAP_PRE_SUPP 1'h1
`define CAP_EXT 1'h1
`define AN_ABLE_RESET 1'h1

// strap sampling, counted in clock edges after reset release
`define STRAP_SAMPLE_AT 2'h2
`define STRAP_DONE 2'h3

// management frame layout
`define MGMT_PHY_ADDR 5'h01
`define MGMT_OP_READ 2'h2
`define MGMT_OP_WRITE 2'h1
`define MGMT_HDR_LAST 5'h0c
`define MGMT_DATA_LAST 5'h0f

`endif

// ===== src/phy_status_pkg.sv
// types shared by the phy status bank
package phy_status_pkg;

    // management frame receiver states
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_HDR = 2'b01,
        ST_TURN = 2'b10,
        ST_DATA = 2'b11
    } mgmt_state_t;

endpackage

// ===== src/pin_sync.sv
// two flip-flop synchroniser for a group of pin inputs
`timescale 1ns/1ps

module pin_sync #(
    parameter int WIDTH = 1
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic nrst_i,
    // asynchronous inputs and their synchronised copies
    input wire logic [WIDTH-1:0] async_i,
    output logic [WIDTH-1:0] sync_o
);

    logic [WIDTH-1:0] meta_reg;
    logic [WIDTH-1:0] sync_reg;

    // first stage is read by the second stage only
    genvar g;
    generate
        for (g = 0; g < WIDTH; g++) begin : g_bit
            always_ff @(posedge clk_i or negedge nrst_i) begin
                if (!nrst_i) begin
                    meta_reg[g] <= 1'b0;
                    sync_reg[g] <= 1'b0;
                end else begin
                    meta_reg[g] <= async_i[g];
                    sync_reg[g] <= meta_reg[g];
                end
            end
        end
    endgenerate

    assign sync_o = sync_reg;

endmodule

// ===== src/phy_status_bank.sv
// phy status and identifier registers behind an internal management serial slave
`timescale 1ns/1ps
`include "phy_status_regs.svh"

module phy_status_bank #(
    // identifier bits; value is arbitrary, not a real maker code
    parameter logic [15:0] ID_HIGH_VALUE = 16'h5a3c
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic nrst_i,
    // internal management path from the mac access control logic
    input wire logic mdc_i,
    input wire logic mdio_i,
    output logic mdio_o,
    output logic mdio_oe_n_o,
    // mode strap pin
    input wire logic an_mode_strap_i,
    // phy state on this clock
    input wire logic an_enable_i,
    input wire logic an_done_i,
    input wire logic link_up_i,
    input wire logic remote_fault_i,
    input wire logic jabber_i
);

    // synchronised pins
    // order inside the synchroniser: clock, data, strap
    logic [2:0] pin_sync_out;
    logic mdc_s;
    logic mdio_s;
    logic strap_s;

    // frame receiver state
    phy_status_pkg::mgmt_state_t state_reg;
    phy_status_pkg::mgmt_state_t state_next;
    // bit count within the current field of the frame
    logic [4:0] cnt_reg;
    logic [4:0] cnt_next;
    logic [12:0] hdr_reg;
    logic [12:0] hdr_next;
    logic [15:0] shift_reg;
    logic [15:0] shift_next;
    logic rd_reg;
    logic rd_next;
    logic mdc_d_reg;
    logic mdio_reg;
    logic mdio_next;
    logic oe_n_reg;
    logic oe_n_next;

    // latched status
    // the fault, link and jabber latches clear in reset, so the first status read after reset shows the link down
    logic rem_fault_reg;
    logic link_reg;
    logic jabber_reg;
    logic an_able_reg;
    // edges counted after reset release until the strap has passed both synchroniser stages
    logic [1:0] strap_wait_reg;

    // decoded wires
    logic mdc_rise;
    logic [12:0] hdr_full;
    logic hdr_start_ok;
    logic [1:0] hdr_op;
    logic [4:0] hdr_phy;
    logic [4:0] hdr_reg_addr;
    logic frame_is_read;
    logic turn_first;
    logic status_read;
    logic an_done_gated;
    logic [15:0] status_word;

    // read data for a register address; unmapped addresses return zero
    // the identifier word is a parameter so each product variant can carry its own value
    function automatic logic [15:0] read_word(input logic [4:0] addr, input logic [15:0] st);
        logic [15:0] w;
        w = 16'h0000;
        if (addr == `PHY_LINK_STATUS_ADDR) begin
            w = st;
        end else if (addr == `PHY_IDENTIFIER_HIGH_ADDR) begin
            w = ID_HIGH_VALUE;
        end
        return w;
    endfunction

    // clock, data and strap all come from outside this domain
    // the management clock is treated as data: every decision is made on clk_i, so mdc must
    // stay high and low for at least two device clocks or a level is missed
    pin_sync #(
        .WIDTH(3)
    ) u_pin_sync (
        .clk_i(clk_i),
        .nrst_i(nrst_i),
        .async_i({mdc_i, mdio_i, an_mode_strap_i}),
        .sync_o(pin_sync_out)
    );

    assign mdc_s = pin_sync_out[2];
    assign mdio_s = pin_sync_out[1];
    assign strap_s = pin_sync_out[0];

    // edge of the management clock, seen after synchronisation
    // the delayed copy resets low, the idle level of mdc, so leaving reset makes no false edge
    assign mdc_rise = mdc_s & ~mdc_d_reg;

    // header fields: start bit, opcode, phy address, register address
    // the phy address is fixed; frames for another address are clocked through with no answer
    assign hdr_full = {hdr_reg[11:0], mdio_s};
    assign hdr_start_ok = hdr_full[12];
    assign hdr_op = hdr_full[11:10];
    assign hdr_phy = hdr_full[9:5];
    assign hdr_reg_addr = hdr_full[4:0];
    assign frame_is_read = hdr_start_ok && (hdr_op == `MGMT_OP_READ) && (hdr_phy == `MGMT_PHY_ADDR);

    // a status read is counted at the edge where the word is captured, so no event slips in between
    // reads of the identifier or of an unmapped address leave the latched flags alone
    assign turn_first = mdc_rise && (state_reg == phy_status_pkg::ST_TURN) && (cnt_reg == 5'h00);
    assign status_read = turn_first && rd_reg && (hdr_reg[4:0] == `PHY_LINK_STATUS_ADDR);

    // completion flag only while negotiation is enabled
    // live, not latched: it drops at once when negotiation is turned off
    assign an_done_gated = an_done_i & an_enable_i;

    // assembled status word
    // capability flags are constants except bit 3, taken from the strap; bits 5, 4, 2 and 1 follow the phy state
    always_comb begin
        status_word = 16'h0000; // reserved bits stay zero
        status_word[`ST_T4_BIT] = `CAP_T4;
        status_word[`ST_X_FD_BIT] = `CAP_X_FD;
        status_word[`ST_X_HD_BIT] = `CAP_X_HD;
        status_word[`ST_10_FD_BIT] = `CAP_10_FD;
        status_word[`ST_10_HD_BIT] = `CAP_10_HD;
        status_word[`ST_PRE_SUPP_BIT] = `CAP_PRE_SUPP;
        status_word[`ST_AN_DONE_BIT] = an_done_gated;
        status_word[`ST_REM_FAULT_BIT] = rem_fault_reg;
        status_word[`ST_AN_ABLE_BIT] = an_able_reg;
        status_word[`ST_LINK_BIT] = link_reg;
        status_word[`ST_JABBER_BIT] = jabber_reg;
        status_word[`ST_EXT_CAP_BIT] = `CAP_EXT;
    end

    // frame receiver: preamble ones are skipped, the first zero is the start bit
    // limitation: a frame cut short is not noticed; the receiver waits for the missing rises
    // and then takes the start of the next frame as the tail of the old one
    // trade-off: no timeout counter, as nothing in the frame format bounds the mdc period
    always_comb begin
        state_next = state_reg;
        cnt_next = cnt_reg;
        hdr_next = hdr_reg;
        shift_next = shift_reg;
        rd_next = rd_reg;
        mdio_next = mdio_reg;
        oe_n_next = oe_n_reg;
        if (mdc_rise) begin
            unique case (state_reg)
                phy_status_pkg::ST_IDLE: begin
                    // no preamble count is kept, so suppressed preambles work
                    if (!mdio_s) begin
                        state_next = phy_status_pkg::ST_HDR;
                        cnt_next = 5'h00;
                        hdr_next = 13'h0000;
                    end
                end
                phy_status_pkg::ST_HDR: begin
                    // the last header bit comes straight from the wire, so no extra rise is needed
                    hdr_next = hdr_full;
                    cnt_next = cnt_reg + 5'h01;
                    if (cnt_reg == `MGMT_HDR_LAST) begin
                        // a bad start bit drops the frame back to idle
                        state_next = hdr_start_ok ? phy_status_pkg::ST_TURN : phy_status_pkg::ST_IDLE;
                        cnt_next = 5'h00;
                        rd_next = frame_is_read;
                    end
                end
                phy_status_pkg::ST_TURN: begin
                    cnt_next = cnt_reg + 5'h01;
                    if (cnt_reg == 5'h00) begin
                        // second turnaround bit is driven low by the responder
                        // the word is captured at the same edge that releases the latched flags
                        if (rd_reg) begin
                            oe_n_next = 1'b0;
                            mdio_next = 1'b0;
                            shift_next = read_word(hdr_reg[4:0], status_word);
                        end
                    end else begin
                        // second turnaround rise puts the top data bit out
                        state_next = phy_status_pkg::ST_DATA;
                        cnt_next = 5'h00;
                        if (rd_reg) begin
                            mdio_next = shift_reg[15];
                            shift_next = {shift_reg[14:0], 1'b0};
                        end
                    end
                end
                phy_status_pkg::ST_DATA: begin
                    // write data is clocked through and thrown away
                    cnt_next = cnt_reg + 5'h01;
                    if (cnt_reg == `MGMT_DATA_LAST) begin
                        // release at the last rise, before the master may start another frame
                        state_next = phy_status_pkg::ST_IDLE;
                        oe_n_next = 1'b1;
                        mdio_next = 1'b0;
                        rd_next = 1'b0;
                    end else if (rd_reg) begin
                        mdio_next = shift_reg[15];
                        shift_next = {shift_reg[14:0], 1'b0};
                    end
                end
            endcase
        end
    end

    // receiver registers
    // the answer leaves about three device clocks after the mdc rise, long before the next rise samples it
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            state_reg <= phy_status_pkg::ST_IDLE;
            cnt_reg <= 5'h00;
            hdr_reg <= 13'h0000;
            shift_reg <= 16'h0000;
            rd_reg <= 1'b0;
            mdc_d_reg <= 1'b0;
            mdio_reg <= 1'b0;
            oe_n_reg <= 1'b1;
        end else begin
            state_reg <= state_next;
            cnt_reg <= cnt_next;
            hdr_reg <= hdr_next;
            shift_reg <= shift_next;
            rd_reg <= rd_next;
            mdc_d_reg <= mdc_s;
            mdio_reg <= mdio_next;
            oe_n_reg <= oe_n_next;
        end
    end

    // sticky faults: a live condition always wins over the release by a read
    // a read that meets a live condition leaves the flag set, so the host sees it again
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            rem_fault_reg <= 1'b0;
            jabber_reg <= 1'b0;
        end else begin
            rem_fault_reg <= remote_fault_i | (rem_fault_reg & ~status_read);
            jabber_reg <= jabber_i | (jabber_reg & ~status_read);
        end
    end

    // link bit latches low; only a read can bring it back up, and only if the link is up then
    // the read that brings the bit back still returns 0, so a short drop is never missed
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            link_reg <= 1'b0;
        end else begin
            link_reg <= link_up_i & (link_reg | status_read);
        end
    end

    // strap is taken once after reset release, when the synchroniser holds a settled value
    // the first edges after release still see the cleared stages, so an earlier sample would read 0
    // the ability bit keeps its reset value until then, and a strap moved later is not followed
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            an_able_reg <= `AN_ABLE_RESET;
            strap_wait_reg <= 2'h0;
        end else begin
            if (strap_wait_reg != `STRAP_DONE) begin
                strap_wait_reg <= strap_wait_reg + 2'h1;
            end
            if (strap_wait_reg == `STRAP_SAMPLE_AT) begin
                an_able_reg <= strap_s;
            end
        end
    end

    // serial answer comes straight from flip-flops
    // the enable is active low and released in reset, so the line is never driven
    // before the receiver state is known
    assign mdio_o = mdio_reg;
    assign mdio_oe_n_o = oe_n_reg;

endmodule

// ===== testbench/phy_status_bank_properties.sv
// assertion checker for the management serial side of the phy status bank
`timescale 1ns/1ps
module phy_status_bank_properties (
    // clock and reset
    input wire logic clk_i,
    input wire logic nrst_i,
    // management path
    input wire logic mdc_i,
    input wire logic mdio_i,
    input wire logic mdio_o,
    input wire logic mdio_oe_n_o,
    // phy state
    input wire logic an_mode_strap_i,
    input wire logic an_enable_i,
    input wire logic an_done_i,
    input wire logic link_up_i,
    input wire logic remote_fault_i,
    input wire logic jabber_i
);
    logic mdc_q;
    logic [4:0] drv_rises;
    logic [4:0] quiet;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!nrst_i);
    // mdc rises seen while driving, and idle mdc cycles; quiet saturates so it never wraps
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            mdc_q <= 1'b0;
            drv_rises <= 5'h00;
            quiet <= 5'h00;
        end else begin
            mdc_q <= mdc_i;
            quiet <= (mdc_i != mdc_q) ? 5'h00 : ((quiet == 5'h1f) ? quiet : quiet + 5'h01);
            drv_rises <= mdio_oe_n_o ? 5'h00 : drv_rises + {4'h0, mdc_i & ~mdc_q};
        end
    end
    sequence s_drive_start; $fell(mdio_oe_n_o); endsequence
    sequence s_release; $rose(mdio_oe_n_o); endsequence
    property p_released_low; mdio_oe_n_o |-> !mdio_o; endproperty
    property p_start_zero; s_drive_start |-> !mdio_o; endproperty
    property p_drive_min; s_drive_start |-> !mdio_oe_n_o [*8]; endproperty
    property p_drive_len; s_release |-> drv_rises == 5'h11; endproperty
    property p_drive_max; !mdio_oe_n_o |-> drv_rises <= 5'h11; endproperty
    property p_bit_stand; $changed(mdio_o) |=> $stable(mdio_o) [*7]; endproperty
    property p_reset_idle; $rose(nrst_i) |-> mdio_oe_n_o && !mdio_o; endproperty
    property p_quiet; quiet == 5'h1f |-> $stable(mdio_o) && $stable(mdio_oe_n_o); endproperty
    a_released_low: assert property (p_released_low) else $error("data high while released");
    a_start_zero: assert property (p_start_zero) else $error("turnaround not driven low");
    a_drive_min: assert property (p_drive_min) else $error("drive dropped early");
    a_drive_len: assert property (p_drive_len) else $error("word length wrong");
    a_drive_max: assert property (p_drive_max) else $error("drive held too long");
    a_bit_stand: assert property (p_bit_stand) else $error("data bit too short");
    a_reset_idle: assert property (p_reset_idle) else $error("not idle after reset");
    a_quiet: assert property (p_quiet) else $error("output moved with mdc idle");
endmodule

bind phy_status_bank phy_status_bank_properties u_props (
    .clk_i(clk_i), .nrst_i(nrst_i), .mdc_i(mdc_i), .mdio_i(mdio_i), .mdio_o(mdio_o),
    .mdio_oe_n_o(mdio_oe_n_o), .an_mode_strap_i(an_mode_strap_i), .an_enable_i(an_enable_i),
    .an_done_i(an_done_i), .link_up_i(link_up_i), .remote_fault_i(remote_fault_i), .jabber_i(jabber_i));

// ===== testbench/mgmt_master.sv
// behavioural mac-side management master driving frames over mdc and mdio
`timescale 1ns/1ps
module mgmt_master (
    // clock
    input wire logic clk_i,
    // management wire
    input wire logic mdio_i,
    output logic mdc_o,
    output logic mdio_o,
    output logic mdio_oe_o
);
    // mdc stands low between frames
    initial begin
        mdc_o = 1'b0;
        mdio_o = 1'b1;
        mdio_oe_o = 1'b0;
    end
    // one bit: data set with mdc low, wire sampled at the rise; 5 clocks each half
    task automatic bit_cycle(input logic d, input logic oe, output logic s);
        mdio_o <= d;
        mdio_oe_o <= oe;
        repeat (5) @(posedge clk_i);
        s = mdio_i;
        mdc_o <= 1'b1;
        repeat (5) @(posedge clk_i);
        mdc_o <= 1'b0;
    endtask
    // whole frame without preamble; a read releases the line from the turnaround on
    task automatic frame(input logic [1:0] op, input logic [4:0] pa, input logic [4:0] ra,
                         input logic [15:0] wd, output logic [16:0] rd);
        logic [31:0] f;
        logic s;
        f = {2'b01, op, pa, ra, 2'b10, wd};
        rd = 17'h00000;
        @(posedge clk_i);
        for (int i = 31; i >= 0; i--) begin
            bit_cycle(f[i], (op != 2'h2) || (i > 17), s);
            if (i <= 16) rd[i] = s;
        end
        mdio_oe_o <= 1'b0;
    endtask
endmodule

// ===== testbench/phy_status_bank_tb.sv
// self-checking bench for the phy status and identifier bank
`timescale 1ns/1ps
`include "phy_status_regs.svh"
module phy_status_bank_tb;
    localparam logic [15:0] ID_VAL = 16'hc35a; // arbitrary identifier value
    logic clk_i = 1'b0;
    logic nrst_i = 1'b0;
    logic strap = 1'b1;
    logic an_en = 1'b0;
    logic an_done = 1'b0;
    logic link = 1'b0;
    logic fault = 1'b0;
    logic jab = 1'b0;
    logic mdc, m_d, m_oe, s_d, s_oe_n, wire_lvl;
    int miscompares = 0;
    int num_checks = 0;
    int cycles = 0;

    phy_status_bank #(.ID_HIGH_VALUE(ID_VAL)) uut (
        .clk_i(clk_i), .nrst_i(nrst_i), .mdc_i(mdc), .mdio_i(wire_lvl), .mdio_o(s_d),
        .mdio_oe_n_o(s_oe_n), .an_mode_strap_i(strap), .an_enable_i(an_en), .an_done_i(an_done),
        .link_up_i(link), .remote_fault_i(fault), .jabber_i(jab));
    mgmt_master mm (.clk_i(clk_i), .mdio_i(wire_lvl), .mdc_o(mdc), .mdio_o(m_d), .mdio_oe_o(m_oe));
    // pull-up holds the line high when nobody drives it
    assign wire_lvl = !s_oe_n ? s_d : (m_oe ? m_d : 1'b1);

    // clock and hang guard; a frame is about 320 cycles
    always #12.5 clk_i = ~clk_i;
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 20000) begin
            miscompares++;
            test_done();
        end
    end

    function automatic logic [15:0] exp_st(input logic st, en, dn, fl, lk, jb);
        return {1'b0, 4'hf, 4'h0, 1'b1, en & dn, fl, st, lk, jb, 1'b1};
    endfunction

    task automatic check(input logic [16:0] got, input logic [16:0] exp);
        num_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("CHECK FAILED %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic rd(input logic [4:0] pa, input logic [4:0] ra, input logic [16:0] e);
        logic [16:0] v;
        mm.frame(2'h2, pa, ra, 16'h0000, v);
        check(v, e);
    endtask

    task automatic rs(input logic [15:0] e);
        rd(`MGMT_PHY_ADDR, `PHY_LINK_STATUS_ADDR, {1'b0, e});
    endtask

    task automatic reset_dut;
        @(posedge clk_i);
        nrst_i <= 1'b0;
        repeat (4) @(posedge clk_i);
        nrst_i <= 1'b1;
        repeat (6) @(posedge clk_i);
    endtask

    task automatic test_done;
        if (miscompares == 0 && num_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    initial begin
        logic [15:0] w;
        logic [16:0] v;
        logic [1:0] ed;
        w = 16'($urandom(92));
        reset_dut();
        rs(16'h7849);
        rd(`MGMT_PHY_ADDR, `PHY_IDENTIFIER_HIGH_ADDR, {1'b0, ID_VAL});
        // an address with no register behind it answers with zero
        rd(`MGMT_PHY_ADDR, 5'(($urandom % 29) + 3), 17'h00000);
        // writes to both words must leave them untouched
        w = 16'($urandom);
        mm.frame(2'h1, `MGMT_PHY_ADDR, `PHY_LINK_STATUS_ADDR, w, v);
        mm.frame(2'h1, `MGMT_PHY_ADDR, `PHY_IDENTIFIER_HIGH_ADDR, ~w, v);
        rs(16'h7849);
        rd(`MGMT_PHY_ADDR, `PHY_IDENTIFIER_HIGH_ADDR, {1'b0, ID_VAL});
        // another phy address gets no answer, the line stays pulled up
        rd(`MGMT_PHY_ADDR ^ 5'(($urandom % 31) + 1), `PHY_LINK_STATUS_ADDR, 17'h1ffff);
        // link comes up: first read still shows the latched loss
        link <= 1'b1;
        rs(16'h7849);
        rs(16'h784d);
        link <= 1'b0;
        repeat (3) @(posedge clk_i);
        link <= 1'b1;
        rs(16'h7849);
        rs(16'h784d);
        // fault held across reads, jabber only a short pulse
        fault <= 1'b1;
        jab <= 1'b1;
        repeat (3) @(posedge clk_i);
        jab <= 1'b0;
        rs(16'h785f);
        rs(16'h785d);
        fault <= 1'b0;
        // an identifier read must not release the latched fault
        rd(`MGMT_PHY_ADDR, `PHY_IDENTIFIER_HIGH_ADDR, {1'b0, ID_VAL});
        rs(16'h785d);
        rs(16'h784d);
        // completion flag against enable: four corners, then random
        for (int i = 0; i < 8; i++) begin
            ed = (i < 4) ? i[1:0] : 2'($urandom);
            an_en <= ed[1];
            an_done <= ed[0];
            rs(exp_st(1'b1, ed[1], ed[0], 1'b0, 1'b1, 1'b0));
        end
        // strap low across a second reset
        an_en <= 1'b0;
        strap <= 1'b0;
        reset_dut();
        rs(exp_st(1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0));
        test_done();
    end
endmodule
